// ===== verilog/srb_pkg.sv
// Purpose: Constants for the special register bank: addresses, resets, fields.
// Assumes: 8-bit register space, register addresses 0x80 to 0xff.
// Notes:   Lookup helpers are constant functions usable at elaboration.
package srb_pkg;
	localparam int SRB_NUM = 38;
	localparam int SRB_IXW = $clog2(SRB_NUM);

	localparam logic [7:0] ADR_PORT_ZERO    = 8'h80;
	localparam logic [7:0] ADR_STACK_PTR    = 8'h81;
	localparam logic [7:0] ADR_PTR0_LO      = 8'h82;
	localparam logic [7:0] ADR_PTR0_HI      = 8'h83;
	localparam logic [7:0] ADR_PTR1_LO      = 8'h84;
	localparam logic [7:0] ADR_PTR1_HI      = 8'h85;
	localparam logic [7:0] ADR_WDOG_RELOAD  = 8'h86;
	localparam logic [7:0] ADR_UART_SPEED   = 8'h87;
	localparam logic [7:0] ADR_TMR_CTRL     = 8'h88;
	localparam logic [7:0] ADR_TMR_MODE     = 8'h89;
	localparam logic [7:0] ADR_TMR0_LO      = 8'h8a;
	localparam logic [7:0] ADR_TMR1_LO      = 8'h8b;
	localparam logic [7:0] ADR_TMR0_HI      = 8'h8c;
	localparam logic [7:0] ADR_TMR1_HI      = 8'h8d;
	localparam logic [7:0] ADR_STRETCH_CTRL = 8'h8e;
	localparam logic [7:0] ADR_PORT_ONE     = 8'h90;
	localparam logic [7:0] ADR_PTR_SELECT   = 8'h92;
	localparam logic [7:0] ADR_SER0_CTRL    = 8'h98;
	localparam logic [7:0] ADR_SER0_BUF     = 8'h99;
	localparam logic [7:0] ADR_IRQ_EN2      = 8'h9a;
	localparam logic [7:0] ADR_SER1_CTRL    = 8'h9b;
	localparam logic [7:0] ADR_SER1_BUF     = 8'h9c;
	localparam logic [7:0] ADR_SER1_RLD_LO  = 8'h9d;
	localparam logic [7:0] ADR_PORT_TWO     = 8'ha0;
	localparam logic [7:0] ADR_IRQ_EN0      = 8'ha8;
	localparam logic [7:0] ADR_IRQ_PRI0     = 8'ha9;
	localparam logic [7:0] ADR_SER0_RLD_LO  = 8'haa;
	localparam logic [7:0] ADR_IRQ_EN1      = 8'hb8;
	localparam logic [7:0] ADR_IRQ_PRI1     = 8'hb9;
	localparam logic [7:0] ADR_SER0_RLD_HI  = 8'hba;
	localparam logic [7:0] ADR_SER1_RLD_HI  = 8'hbb;
	localparam logic [7:0] ADR_MOVX_PAGE    = 8'hbf;
	localparam logic [7:0] ADR_IRQ_REQ_CTRL = 8'hc0;
	localparam logic [7:0] ADR_EXT_IRQ_POL  = 8'hc8;
	localparam logic [7:0] ADR_STATUS_WORD  = 8'hd0;
	localparam logic [7:0] ADR_BAUD_CTRL    = 8'hd8;
	localparam logic [7:0] ADR_ACCUM        = 8'he0;
	localparam logic [7:0] ADR_MULDIV_AUX   = 8'hf0;

	localparam logic [7:0] SRB_ADDR [SRB_NUM] = '{
		ADR_PORT_ZERO, ADR_STACK_PTR, ADR_PTR0_LO, ADR_PTR0_HI, ADR_PTR1_LO,
		ADR_PTR1_HI, ADR_WDOG_RELOAD, ADR_UART_SPEED, ADR_TMR_CTRL, ADR_TMR_MODE,
		ADR_TMR0_LO, ADR_TMR1_LO, ADR_TMR0_HI, ADR_TMR1_HI, ADR_STRETCH_CTRL,
		ADR_PORT_ONE, ADR_PTR_SELECT, ADR_SER0_CTRL, ADR_SER0_BUF, ADR_IRQ_EN2,
		ADR_SER1_CTRL, ADR_SER1_BUF, ADR_SER1_RLD_LO, ADR_PORT_TWO, ADR_IRQ_EN0,
		ADR_IRQ_PRI0, ADR_SER0_RLD_LO, ADR_IRQ_EN1, ADR_IRQ_PRI1, ADR_SER0_RLD_HI,
		ADR_SER1_RLD_HI, ADR_MOVX_PAGE, ADR_IRQ_REQ_CTRL, ADR_EXT_IRQ_POL,
		ADR_STATUS_WORD, ADR_BAUD_CTRL, ADR_ACCUM, ADR_MULDIV_AUX};

	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_PORT        = 8'hff;
	localparam logic [7:0] RST_STACK       = 8'h07;
	localparam logic [7:0] RST_STRETCH     = 8'h01;
	localparam logic [7:0] RST_SER0_RLD_LO = 8'hd9;
	localparam logic [7:0] RST_RLD_HI      = 8'h03;

	localparam logic [7:0] SRB_UNMAPPED_RD = 8'h00;
	localparam logic [7:0] SRB_FULL_MASK   = 8'hff;
	localparam logic [7:0] SRB_BAUD_MASK   = 8'h80;
	localparam logic [7:0] SRB_ONE_BIT     = 8'h01;
	localparam logic [7:0] SRB_STACK_STEP  = 8'h01;
	localparam int         SRB_BITADR_LSBS = 3;

	localparam int PSW_PARITY  = 0;
	localparam int PSW_USER1   = 1;
	localparam int PSW_OVF     = 2;
	localparam int PSW_BANK_LO = 3;
	localparam int PSW_BANK_HI = 4;
	localparam int PSW_USER0   = 5;
	localparam int PSW_HALF    = 6;
	localparam int PSW_CARRY   = 7;
	localparam int STRETCH_MSB = 2;
	localparam int SEL_BIT     = 0;
	localparam int BAUD_BIT    = 7;
	localparam logic [2:0] BANK_LSBS = 3'h0;

	function automatic int srb_ix(input logic [7:0] a);
		int r;
		r = 0;
		for (int i = 0; i < SRB_NUM; i++) begin
			if (SRB_ADDR[i] == a) r = i;
		end
		return r;
	endfunction

	function automatic logic [SRB_IXW:0] srb_find(input logic [7:0] a);
		logic [SRB_IXW:0] r;
		r = '0;
		for (int i = 0; i < SRB_NUM; i++) begin
			if (SRB_ADDR[i] == a) r = {1'b1, SRB_IXW'(i)};
		end
		return r;
	endfunction

	function automatic logic [7:0] srb_rst_val(input logic [7:0] a);
		logic [7:0] r;
		r = RST_ZERO;
		if (a == ADR_PORT_ZERO || a == ADR_PORT_ONE) r = RST_PORT;
		if (a == ADR_STACK_PTR) r = RST_STACK;
		if (a == ADR_STRETCH_CTRL) r = RST_STRETCH;
		if (a == ADR_SER0_RLD_LO) r = RST_SER0_RLD_LO;
		if (a == ADR_SER0_RLD_HI || a == ADR_SER1_RLD_HI) r = RST_RLD_HI;
		return r;
	endfunction

	function automatic logic [7:0] srb_wmask(input logic [7:0] a);
		return (a == ADR_BAUD_CTRL) ? SRB_BAUD_MASK : SRB_FULL_MASK;
	endfunction
endpackage

// ===== verilog/srb_special_reg_bank.sv
// Purpose: Special register bank of an 8-bit core, byte and bit access.
// Assumes: Core drives access strobes on core_clk_i; one access per cycle.
// Notes:   Software writes win over same-cycle hardware updates, except the recomputed parity bit.
`timescale 1ns/1ns
// Functional notes
// [R01] Unoccupied addresses read undefined (zero here); writes there change nothing.
// [R02] Addresses multiple of eight allow bit access; others only byte access.
// [R03] Reset: ports 0,1 to 0xff, stack 0x07, stretch 0x01, others zero except serial reloads ([R04], [R05]).
// [R04] Serial 0 reload low resets 0xd9; serial 1 reload low resets zero.
// [R05] Both serial reload high bytes reset to 0x03.
// [R06] Paging register supplies upper address byte for indirect external transfers.
// [R07] Baud rate control implements only bit 7.
// [R08] Timer-2 control location holds external irq 2 and 3 polarity.
// [R09] Aux operand register used by multiply/divide, else free scratch.
// [R10] Status word: carry 7, half carry 6, user 5, overflow 2, user 1, parity 0.
// [R11] Status bits 4:3 select working bank base 0x00, 0x08, 0x10, 0x18.
// [R12] Parity bit keeps accumulator plus parity at even count of ones.
// [R13] Pointer select at 0x92 resets to zero, first pointer active.
// [R14] Pointer select bit 0 picks the active data pointer.
// [R15] Stretch control low three bits give external access stretch 0 to 7.
// [R16] Stack pointer increments before push, first push lands at 0x08.
// [R17] Parity recomputed every cycle; software writes to it do not last.
module srb_special_reg_bank (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_rd_i,
	input  wire logic        bit_wr_i,
	input  wire logic        bit_rd_i,
	input  wire logic [2:0]  bit_sel_i,
	input  wire logic        bit_val_i,
	input  wire logic        acc_ld_i,
	input  wire logic [7:0]  acc_d_i,
	input  wire logic        aux_ld_i,
	input  wire logic [7:0]  aux_d_i,
	input  wire logic        flag_ld_i,
	input  wire logic        carry_i,
	input  wire logic        half_i,
	input  wire logic        ovf_i,
	input  wire logic        push_i,
	input  wire logic        pop_i,
	output logic      [7:0]  sfr_rdata_o,
	output logic             sfr_hit_o,
	output logic             bit_rdata_o,
	output logic      [15:0] dptr_o,
	output logic      [7:0]  movx_page_o,
	output logic      [4:0]  bank_base_o,
	output logic      [2:0]  stretch_o,
	output logic             baud_sel_o,
	output logic      [7:0]  irq_pol_o,
	output logic      [7:0]  port0_o,
	output logic      [7:0]  port1_o,
	output logic      [7:0]  port2_o,
	output logic      [7:0]  stack_ptr_o,
	output logic      [7:0]  acc_o,
	output logic      [7:0]  aux_o,
	output logic      [7:0]  psw_o
);
	localparam int NUM = srb_pkg::SRB_NUM;
	localparam int IXW = srb_pkg::SRB_IXW;
	localparam logic [IXW-1:0] IX_STACK = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_STACK_PTR));
	localparam logic [IXW-1:0] IX_P0LO  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PTR0_LO));
	localparam logic [IXW-1:0] IX_P0HI  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PTR0_HI));
	localparam logic [IXW-1:0] IX_P1LO  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PTR1_LO));
	localparam logic [IXW-1:0] IX_P1HI  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PTR1_HI));
	localparam logic [IXW-1:0] IX_STR   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_STRETCH_CTRL));
	localparam logic [IXW-1:0] IX_SEL   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PTR_SELECT));
	localparam logic [IXW-1:0] IX_PAGE  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_MOVX_PAGE));
	localparam logic [IXW-1:0] IX_POL   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_EXT_IRQ_POL));
	localparam logic [IXW-1:0] IX_PSW   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_STATUS_WORD));
	localparam logic [IXW-1:0] IX_BAUD  = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_BAUD_CTRL));
	localparam logic [IXW-1:0] IX_ACC   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_ACCUM));
	localparam logic [IXW-1:0] IX_AUX   = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_MULDIV_AUX));
	localparam logic [IXW-1:0] IX_PORT0 = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PORT_ZERO));
	localparam logic [IXW-1:0] IX_PORT1 = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PORT_ONE));
	localparam logic [IXW-1:0] IX_PORT2 = IXW'(srb_pkg::srb_ix(srb_pkg::ADR_PORT_TWO));

	logic [NUM-1:0][7:0] regs_r;
	logic [NUM-1:0][7:0] regs_nxt;
	logic [IXW:0]        find_w;
	logic                hit_w;
	logic [IXW-1:0]      ix_w;
	logic                wr_hit_w;
	logic                bit_adr_w;
	logic                bit_ok_w;
	logic [7:0]          bit_mask_w;
	logic [7:0]          bit_byte_w;
	logic [7:0]          wmask_w;
	logic [7:0]          rd_byte_w;
	logic [7:0]          rdata_r;
	logic                hit_r;
	logic                bit_r;

	// Address decode
	assign find_w     = srb_pkg::srb_find(sfr_addr_i);
	assign hit_w      = find_w[IXW];
	assign ix_w       = find_w[IXW-1:0];
	assign wr_hit_w   = sfr_wr_i & hit_w; // [R01]
	assign bit_adr_w  = sfr_addr_i[srb_pkg::SRB_BITADR_LSBS-1:0] == '0; // [R02]
	assign bit_ok_w   = bit_wr_i & hit_w & bit_adr_w; // [R02]
	assign bit_mask_w = srb_pkg::SRB_ONE_BIT << bit_sel_i;
	assign bit_byte_w = bit_val_i ? (regs_r[ix_w] | bit_mask_w) : (regs_r[ix_w] & ~bit_mask_w);
	assign wmask_w    = srb_pkg::srb_wmask(sfr_addr_i); // [R07]
	assign rd_byte_w  = hit_w ? regs_r[ix_w] : srb_pkg::SRB_UNMAPPED_RD; // [R01]

	// Next state of the whole bank
	always_comb begin
		regs_nxt = regs_r;
		if (acc_ld_i) begin
			regs_nxt[IX_ACC] = acc_d_i;
		end
		if (aux_ld_i) begin
			regs_nxt[IX_AUX] = aux_d_i; // [R09]
		end
		if (flag_ld_i) begin
			regs_nxt[IX_PSW][srb_pkg::PSW_CARRY] = carry_i; // [R10]
			regs_nxt[IX_PSW][srb_pkg::PSW_HALF]  = half_i; // [R10]
			regs_nxt[IX_PSW][srb_pkg::PSW_OVF]   = ovf_i; // [R10]
		end
		if (push_i && !pop_i) begin
			regs_nxt[IX_STACK] = regs_r[IX_STACK] + srb_pkg::SRB_STACK_STEP; // [R16]
		end else if (pop_i && !push_i) begin
			regs_nxt[IX_STACK] = regs_r[IX_STACK] - srb_pkg::SRB_STACK_STEP;
		end
		if (wr_hit_w) begin
			regs_nxt[ix_w] = sfr_wdata_i & wmask_w; // [R01] [R07]
		end else if (bit_ok_w) begin
			regs_nxt[ix_w] = bit_byte_w & wmask_w; // [R02]
		end
		regs_nxt[IX_PSW][srb_pkg::PSW_PARITY] = ^regs_nxt[IX_ACC]; // [R12] [R17]
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < NUM; i++) begin
				regs_r[i] <= srb_pkg::srb_rst_val(srb_pkg::SRB_ADDR[i]); // [R03] [R04] [R05] [R13]
			end
		end else begin
			regs_r <= regs_nxt;
		end
	end

	// Registered read port
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r <= srb_pkg::RST_ZERO;
			hit_r   <= 1'b0;
			bit_r   <= 1'b0;
		end else begin
			if (sfr_rd_i) begin
				rdata_r <= rd_byte_w; // [R01]
				hit_r   <= hit_w;
			end
			if (bit_rd_i) begin
				bit_r <= hit_w & bit_adr_w & rd_byte_w[bit_sel_i]; // [R02]
			end
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign sfr_hit_o   = hit_r;
	assign bit_rdata_o = bit_r;
	assign dptr_o      = regs_r[IX_SEL][srb_pkg::SEL_BIT] ? {regs_r[IX_P1HI], regs_r[IX_P1LO]}
	                                                       : {regs_r[IX_P0HI], regs_r[IX_P0LO]}; // [R14]
	assign movx_page_o = regs_r[IX_PAGE]; // [R06]
	assign bank_base_o = {regs_r[IX_PSW][srb_pkg::PSW_BANK_HI:srb_pkg::PSW_BANK_LO],
	                      srb_pkg::BANK_LSBS}; // [R11]
	assign stretch_o   = regs_r[IX_STR][srb_pkg::STRETCH_MSB:0]; // [R15]
	assign baud_sel_o  = regs_r[IX_BAUD][srb_pkg::BAUD_BIT]; // [R07]
	assign irq_pol_o   = regs_r[IX_POL]; // [R08]
	assign port0_o     = regs_r[IX_PORT0];
	assign port1_o     = regs_r[IX_PORT1];
	assign port2_o     = regs_r[IX_PORT2];
	assign stack_ptr_o = regs_r[IX_STACK];
	assign acc_o       = regs_r[IX_ACC];
	assign aux_o       = regs_r[IX_AUX];
	assign psw_o       = regs_r[IX_PSW];

	// Checks
	logic hw_busy_w;
	logic rst_match_w;
	logic first_r;
	assign hw_busy_w = acc_ld_i | aux_ld_i | flag_ld_i | push_i | pop_i;
	always_comb begin
		rst_match_w = 1'b1;
		for (int i = 0; i < NUM; i++) begin
			if (regs_r[i] != srb_pkg::srb_rst_val(srb_pkg::SRB_ADDR[i])) rst_match_w = 1'b0;
		end
	end
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	chk_reset_image: assert property (first_r |-> rst_match_w) // [R03]
		else $error("Bank not at reset values after reset");
	chk_unmapped_write: assert property ( // [R01]
		sfr_wr_i && !hit_w && !bit_wr_i && !hw_busy_w |=> regs_r == $past(regs_r))
		else $error("Write to unoccupied address changed state");
	chk_unmapped_read: assert property ( // [R01]
		sfr_rd_i && !hit_w |=> !sfr_hit_o && sfr_rdata_o == srb_pkg::SRB_UNMAPPED_RD)
		else $error("Unoccupied read not flagged");
	chk_bit_refused: assert property ( // [R02]
		bit_wr_i && !bit_adr_w && !sfr_wr_i && !hw_busy_w |=> regs_r == $past(regs_r))
		else $error("Bit write took effect at byte-only address");
	chk_bit_write: assert property ( // [R02]
		bit_ok_w && !sfr_wr_i && !hw_busy_w && ix_w != IX_PSW && ix_w != IX_BAUD
		|=> regs_r[$past(ix_w)][$past(bit_sel_i)] == $past(bit_val_i))
		else $error("Bit write lost");
	chk_parity_even: assert property (!(^{regs_r[IX_ACC], psw_o[srb_pkg::PSW_PARITY]})) // [R12]
		else $error("Parity does not make even count");
	chk_stack_push: assert property ( // [R16]
		push_i && !pop_i && !wr_hit_w |=> stack_ptr_o == $past(stack_ptr_o) + 8'h01)
		else $error("Stack pointer not incremented on push");
	chk_ptr_select: assert property ( // [R14]
		wr_hit_w && ix_w == IX_SEL && sfr_wdata_i[srb_pkg::SEL_BIT]
		|=> regs_r[IX_SEL][srb_pkg::SEL_BIT] && dptr_o == {regs_r[IX_P1HI], regs_r[IX_P1LO]})
		else $error("Second pointer not selected");
	chk_bank_base: assert property ( // [R11]
		wr_hit_w && ix_w == IX_PSW |=> bank_base_o == {$past(sfr_wdata_i[4:3]), 3'h0})
		else $error("Bank base mismatch");
	chk_baud_mask: assert property (regs_r[IX_BAUD][6:0] == 7'h00) // [R07]
		else $error("Unimplemented baud bits set");
	chk_aux_load: assert property ( // [R09]
		aux_ld_i && !(wr_hit_w && ix_w == IX_AUX) && !bit_ok_w |=> aux_o == $past(aux_d_i))
		else $error("Aux operand load lost");
	chk_page_out: assert property ( // [R06]
		wr_hit_w && ix_w == IX_PAGE |=> movx_page_o == $past(sfr_wdata_i))
		else $error("Page byte not driven");
	chk_stretch_out: assert property ( // [R15]
		wr_hit_w && ix_w == IX_STR |=> stretch_o == $past(sfr_wdata_i[2:0]))
		else $error("Stretch value not driven");
	chk_flag_load: assert property ( // [R10]
		flag_ld_i && !wr_hit_w && !bit_ok_w |=> psw_o[7] == $past(carry_i) && psw_o[2] == $past(ovf_i))
		else $error("Hardware flags not stored");
	chk_irq_polarity: assert property ( // [R08]
		wr_hit_w && ix_w == IX_POL |=> irq_pol_o == $past(sfr_wdata_i))
		else $error("Polarity register not driven");

	cov_push_twice: cover property (push_i ##1 push_i);
	cov_bit_write: cover property (bit_ok_w && !sfr_wr_i);
	cov_unmapped_rd: cover property (sfr_rd_i && !hit_w);
	cov_bank_three: cover property (bank_base_o == 5'h18);
endmodule

// ===== testbench/srb_core_model.sv
// Purpose: Core side model issuing register and hardware strobes.
// Assumes: Signals change 5 ns after the rising edge and hold one edge.
// Notes:   Data lines invert after each access so stale values never match.
`timescale 1ns/1ns
module srb_core_model (
	input  wire logic       core_clk_i,
	output logic      [8:0] strobe_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] data_o,
	output logic      [2:0] bit_sel_o
);
	initial begin
		strobe_o = 9'h000;
		addr_o = 8'h00;
		data_o = 8'h00;
		bit_sel_o = 3'h0;
	end
	// One access taken at the next edge, then released
	task automatic go(input logic [8:0] s, input logic [7:0] a, input logic [7:0] d,
		input logic [2:0] b);
		@(posedge core_clk_i);
		#5;
		strobe_o = s;
		addr_o = a;
		data_o = d;
		bit_sel_o = b;
		@(posedge core_clk_i);
		#5;
		strobe_o = 9'h000;
		addr_o = ~a;
		data_o = ~d;
		bit_sel_o = ~b;
	endtask
endmodule

// ===== testbench/cpu_special_register_bank_bench.sv
// Purpose: Self-checking bench for the special register bank.
// Assumes: Model array mirrors every mapped register.
// Notes:   Random data from a fixed seed.
`timescale 1ns/1ns
module cpu_special_register_bank_bench;
	localparam logic [8:0] S_WR = 9'h100, S_RD = 9'h080, S_BWR = 9'h040, S_BRD = 9'h020;
	localparam logic [8:0] S_ACC = 9'h010, S_AUX = 9'h008, S_FLG = 9'h004;
	localparam logic [8:0] S_PSH = 9'h002, S_POP = 9'h001;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	wire  [8:0]  s;
	wire  [7:0]  a, d;
	wire  [2:0]  b;
	logic [7:0]  rdata, p0, p1, p2, sp, acc, aux, program_status_word, movx, pol;
	logic        hit, bitq, baud;
	logic [15:0] dptr;
	logic [4:0]  bank;
	logic [2:0]  str;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [7:0]  mdl [256];
	bit          mapped [256];
	int          addrs [$];
	logic [7:0]  unm [6] = '{8'h8f, 8'h91, 8'h94, 8'hb0, 8'hf8, 8'hff};
	logic [7:0]  bad [7] = '{8'hd0, 8'hd8, 8'he0, 8'h80, 8'h81, 8'h8e, 8'h94};
	always #25 core_clk_i = ~core_clk_i;
	srb_core_model srb_core_model_inst (.core_clk_i(core_clk_i), .strobe_o(s), .addr_o(a),
		.data_o(d), .bit_sel_o(b));
	srb_special_reg_bank srb_special_reg_bank_inst (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .sfr_addr_i(a), .sfr_wr_i(s[8]), .sfr_wdata_i(d),
		.sfr_rd_i(s[7]), .bit_wr_i(s[6]), .bit_rd_i(s[5]), .bit_sel_i(b), .bit_val_i(d[0]),
		.acc_ld_i(s[4]), .acc_d_i(d), .aux_ld_i(s[3]), .aux_d_i(d), .flag_ld_i(s[2]),
		.carry_i(d[2]), .half_i(d[1]), .ovf_i(d[0]), .push_i(s[1]), .pop_i(s[0]),
		.sfr_rdata_o(rdata), .sfr_hit_o(hit), .bit_rdata_o(bitq), .dptr_o(dptr),
		.movx_page_o(movx), .bank_base_o(bank), .stretch_o(str), .baud_sel_o(baud),
		.irq_pol_o(pol), .port0_o(p0), .port1_o(p1), .port2_o(p2), .stack_ptr_o(sp),
		.acc_o(acc), .aux_o(aux), .psw_o(program_status_word));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask
	function automatic logic [7:0] rst_exp(input logic [7:0] x);
		case (x)
			8'h80, 8'h90: return 8'hff;
			8'h81: return 8'h07;
			8'h8e: return 8'h01;
			8'haa: return 8'hd9;
			8'hba, 8'hbb: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction
	function automatic void fix();
		mdl[8'hd8] = mdl[8'hd8] & 8'h80;
		mdl[8'hd0][0] = ^mdl[8'he0];
	endfunction
	task automatic mwr(input logic [7:0] x, input logic [7:0] v);
		srb_core_model_inst.go(S_WR, x, v, 3'h0);
		if (mapped[x]) mdl[x] = v;
		fix();
	endtask
	task automatic rdc(input logic [7:0] x);
		srb_core_model_inst.go(S_RD, x, 8'h00, 3'h0);
		chk("read data", mapped[x] ? mdl[x] : 8'h00, rdata);
		chk("read hit", {7'h0, mapped[x]}, {7'h0, hit});
	endtask
	task automatic rdall();
		foreach (addrs[i]) rdc(addrs[i][7:0]);
	endtask
	task automatic outs();
		logic [15:0] p;
		p = mdl[8'h92][0] ? {mdl[8'h85], mdl[8'h84]} : {mdl[8'h83], mdl[8'h82]};
		chk("dptr high", p[15:8], dptr[15:8]);
		chk("dptr low", p[7:0], dptr[7:0]);
		chk("movx page", mdl[8'hbf], movx);
		chk("bank base", {3'h0, mdl[8'hd0][4:3], 3'h0}, {3'h0, bank});
		chk("stretch", {5'h0, mdl[8'h8e][2:0]}, {5'h0, str});
		chk("baud", {7'h0, mdl[8'hd8][7]}, {7'h0, baud});
		chk("irq polarity", mdl[8'hc8], pol);
		chk("port0", mdl[8'h80], p0);
		chk("port1", mdl[8'h90], p1);
		chk("port2", mdl[8'ha0], p2);
		chk("stack", mdl[8'h81], sp);
		chk("acc", mdl[8'he0], acc);
		chk("aux", mdl[8'hf0], aux);
		chk("status", mdl[8'hd0], program_status_word);
	endtask
	task automatic bit_op(input logic [7:0] x, input logic [2:0] n, input logic v);
		logic ok;
		ok = mapped[x] && x[2:0] == 3'h0;
		srb_core_model_inst.go(S_BWR, x, {7'h0, v}, n);
		if (ok) mdl[x][n] = v;
		fix();
		srb_core_model_inst.go(S_BRD, x, 8'h00, n);
		chk("bit read", {7'h0, ok && mdl[x][n]}, {7'h0, bitq});
	endtask
	task automatic hw(input logic [8:0] k, input logic [7:0] v);
		srb_core_model_inst.go(k, 8'h00, v, 3'h0);
		if (k == S_ACC) mdl[8'he0] = v;
		if (k == S_AUX) mdl[8'hf0] = v;
		if (k == S_FLG) mdl[8'hd0] = {v[2:1], mdl[8'hd0][5:3], v[0], mdl[8'hd0][1:0]};
		if (k == S_PSH) mdl[8'h81] = mdl[8'h81] + 8'h01;
		if (k == S_POP) mdl[8'h81] = mdl[8'h81] - 8'h01;
		fix();
		outs();
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc >= 20000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(20));
		foreach (mdl[i]) mdl[i] = 8'h00;
		for (int i = 0; i < srb_pkg::SRB_NUM; i++) begin
			addrs.push_back(int'(srb_pkg::SRB_ADDR[i]));
			mapped[srb_pkg::SRB_ADDR[i]] = 1'b1;
			mdl[srb_pkg::SRB_ADDR[i]] = rst_exp(srb_pkg::SRB_ADDR[i]);
		end
		repeat (12) @(posedge core_clk_i);
		#5;
		reset_i = 1'b0;
		rdall();
		outs();
		$display("test reset values done");
		hw(S_PSH, 8'h00);
		hw(S_PSH | S_POP, 8'h00);
		hw(S_POP, 8'h00);
		$display("test stack done");
		repeat (6) begin
			foreach (addrs[i]) mwr(addrs[i][7:0], 8'($urandom));
			outs();
			rdall();
		end
		$display("test random writes done");
		foreach (unm[i]) mwr(unm[i], 8'($urandom));
		foreach (unm[i]) rdc(unm[i]);
		rdall();
		$display("test unmapped done");
		foreach (bad[i]) for (int n = 0; n < 8; n++) bit_op(bad[i], 3'(n), 1'($urandom));
		for (int k = 0; k < 4; k++) begin
			bit_op(8'hd0, 3'h3, k[0]);
			bit_op(8'hd0, 3'h4, k[1]);
			outs();
		end
		$display("test bit access done");
		repeat (16) begin
			hw(S_ACC, 8'($urandom));
			hw(S_AUX, 8'($urandom));
			hw(S_FLG, 8'($urandom));
		end
		rdall();
		$display("test hardware loads done");
		end_sim();
	end
endmodule
